// ---- common/acdri_pkg.sv ----
// Purpose: Shared constants and types for the converter command decode and result info block.
// Assumes: 32-bit AHB-Lite register bus, byte addresses, one register per aligned word.
// Notes: Register fields sit in the low bits of each word; higher bits read as zero.
package acdri_pkg;

    // Bus widths and the AHB-Lite codes this slave recognises.
    localparam int unsigned HADDR_W = 32;
    localparam int unsigned HDATA_W = 32;
    localparam int unsigned DEC_W = 8;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] HSIZE_WORD = 3'h2;

    // Register byte offsets.
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_MASK = 8'h08;
    localparam logic [7:0] OFF_INTERMEDIATE_INFO = 8'h0C;
    localparam logic [7:0] OFF_LIST_END_INFO = 8'h10;
    localparam logic [7:0] OFF_CMD_WORD_0 = 8'h14;

    // Control register fields.
    localparam int unsigned CTRL_W = 4;
    localparam int unsigned CTRL_ENABLE_BIT = 0;
    localparam int unsigned CTRL_SOFT_RESET_BIT = 1;
    localparam int unsigned CTRL_SPECIAL_MODE_ACCESS_BIT = 2;
    localparam int unsigned CTRL_RESTART_MODE_BIT = 3;

    // Info register fields: active command list and active result list.
    localparam int unsigned INFO_CMD_LIST_BIT = 7;
    localparam int unsigned INFO_RESULT_LIST_BIT = 6;

    // Command word 0 fields (bits 31..24 of the full command word).
    localparam int unsigned CMD_TYPE_HI = 7;
    localparam int unsigned CMD_TYPE_LO = 6;
    localparam int unsigned CMD_FLAG_HI = 3;
    localparam int unsigned CMD_FLAG_LO = 0;
    localparam logic [7:0] CMD_WORD_MASK = 8'hCF;

    // Command types.
    localparam logic [1:0] CT_NORMAL = 2'h0;
    localparam logic [1:0] CT_END_SEQ = 2'h1;
    localparam logic [1:0] CT_END_WRAP = 2'h2;
    localparam logic [1:0] CT_END_WAIT = 2'h3;

    // Status and mask layout: bit 0 list end, bits 15..1 conversion flags.
    localparam int unsigned NUM_FLAGS = 15;
    localparam int unsigned STAT_W = 16;
    localparam int unsigned STAT_LIST_END_BIT = 0;

    // Values after reset.
    localparam logic [3:0] CTRL_RST = 4'h0;
    localparam logic [7:0] CMD_WORD_RST = 8'h00;
    localparam logic [7:0] INFO_RST = 8'h00;
    localparam logic [15:0] STAT_RST = 16'h0000;
    localparam logic [15:0] MASK_RST = 16'h0000;

    // Sequencer states.
    typedef enum logic [2:0] {
        ST_STOP,
        ST_RUN,
        ST_WAIT_TRIG,
        ST_WAIT_RESTART,
        ST_WAIT_TRIG_ONLY
    } acdri_seq_t;

endpackage

// ---- verilog/acdri_cmd_decode.sv ----
// Purpose: Decodes command type and flag select code of command word 0.
// Assumes: Purely combinational; the caller registers the results.
// Notes: Flag select code 0 yields an all-zero flag vector.
`timescale 1ns/1ps
module acdri_cmd_decode #(
    parameter int unsigned NUM_FLAGS = acdri_pkg::NUM_FLAGS
) (
    input wire logic [7:0] cmdWord,
    output logic [1:0] cmdType,
    output logic isListEnd,
    output logic [NUM_FLAGS:1] flagVec
);
    import acdri_pkg::*;

    // A four-bit code cannot address more than fifteen flags.
    if (NUM_FLAGS < 1 || NUM_FLAGS > 15) begin : g_bad_flags
        $error("NUM_FLAGS must lie between 1 and 15.");
    end

    // Binary code k sets only flag k, so the result is one-hot or zero.
    function automatic logic [NUM_FLAGS:1] codeToOneHot(input logic [3:0] code);
        logic [NUM_FLAGS:1] v;
        v = '0;
        for (int k = 1; k <= NUM_FLAGS; k++) begin
            if (code == 4'(k)) begin
                v[k] = 1'b1;
            end
        end
        return v;
    endfunction

    // Type field and flag select field decode.
    assign cmdType = cmdWord[CMD_TYPE_HI:CMD_TYPE_LO];
    assign isListEnd = cmdWord[CMD_TYPE_HI]; // Types 10 and 11 end the list.
    assign flagVec = codeToOneHot(cmdWord[CMD_FLAG_HI:CMD_FLAG_LO]);

endmodule

// ---- verilog/acdri_ahb_slave.sv ----
// Purpose: AHB-Lite slave front end: captures address phases and paces data phases.
// Assumes: Single word transfers; the one slave's hreadyout is the bus hready.
// Notes: Writes finish with no wait state, reads with one.
`timescale 1ns/1ps
module acdri_ahb_slave (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic [acdri_pkg::HADDR_W-1:0] haddr,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    output logic wrEn,
    output logic rdLoad,
    output logic [acdri_pkg::DEC_W-1:0] busAddr,
    output logic hreadyout
);
    import acdri_pkg::*;

    logic wrPend_q;
    logic rdPend_q;
    logic ready_q;
    logic [DEC_W-1:0] addr_q;
    wire addrTaken;

    // Only word transfers are taken; other sizes pass as idle with an OKAY answer.
    assign addrTaken = hsel & hready & (htrans == HTRANS_NONSEQ) & (hsize == HSIZE_WORD);

    // The read wait state lets a write of the previous data phase settle first.
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            wrPend_q <= 1'b0;
            rdPend_q <= 1'b0;
            ready_q <= 1'b1;
            addr_q <= '0;
        end else begin
            wrPend_q <= addrTaken & hwrite;
            rdPend_q <= addrTaken & ~hwrite;
            ready_q <= ~(addrTaken & ~hwrite);
            if (addrTaken) begin
                addr_q <= haddr[DEC_W-1:0];
            end
        end
    end

    // Strobes for the register file.
    assign wrEn = wrPend_q;
    assign rdLoad = rdPend_q;
    assign busAddr = addr_q;
    assign hreadyout = ready_q;

endmodule

// ---- verilog/acdri_top.sv ----
// Purpose: Command decode, sequencer stepping and list-end result info capture.
// Assumes: cmdDone pulses once per command, after its result is stored to RAM.
// Notes: Registers over AHB-Lite; one level interrupt from sticky status bits.
//
// Summary of operation
// - Intermediate info updates with the conversion flag.
// - List-end info cleared by soft reset, disable.
// - Info bit 7 keeps active command list.
// - Info bit 6 keeps active result list.
// - List-end flag rises with the info update.
// - Command word 0 writable only in special mode.
// - Bits 31..30 select the command type.
// - Type 00 continues; 01 waits for trigger, restart.
// - Type 10 wraps and keeps converting.
// - Type 11 wraps, then waits by mode.
// - Flag code k sets only flag k.
// - List-end flag only from list-end commands.
`timescale 1ns/1ps
module acdri_top (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic [acdri_pkg::HADDR_W-1:0] haddr,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [acdri_pkg::HDATA_W-1:0] hwdata,
    output logic hreadyout,
    output logic hresp,
    output logic [acdri_pkg::HDATA_W-1:0] hrdata,
    input wire logic cmdDone,
    input wire logic activeCmdList,
    input wire logic activeResultList,
    input wire logic trigger,
    input wire logic restart,
    output logic [7:0] cmdWord,
    output logic [acdri_pkg::NUM_FLAGS:1] conversionFlagVector,
    output logic listEndFlag,
    output logic cmdAdvance,
    output logic listWrap,
    output logic seqRunning,
    output logic irq
);
    import acdri_pkg::*;

    logic [CTRL_W-1:0] ctrl_q;
    logic [7:0] cmdWord_q;
    logic [STAT_W-1:0] status_q;
    logic [STAT_W-1:0] mask_q;
    logic [7:0] intermediateResultInfo_q;
    logic [7:0] endOfListResultInfo_q;
    logic [NUM_FLAGS:1] convFlag_q;
    logic listEndFlag_q;
    logic cmdAdvance_q;
    logic listWrap_q;
    logic seqRunning_q;
    logic irq_q;
    logic hresp_q;
    logic [HDATA_W-1:0] hrdata_q;
    acdri_seq_t seqState_q;
    acdri_seq_t seqState_d;
    logic [1:0] cmdType;
    logic isListEnd;
    logic [NUM_FLAGS:1] decFlags;
    logic wrEn;
    logic rdLoad;
    logic [DEC_W-1:0] busAddr;

    // Bus front end.
    acdri_ahb_slave u_slave (
        .mclk(mclk),
        .nrst(nrst),
        .hsel(hsel),
        .htrans(htrans),
        .haddr(haddr),
        .hwrite(hwrite),
        .hsize(hsize),
        .hready(hready),
        .wrEn(wrEn),
        .rdLoad(rdLoad),
        .busAddr(busAddr),
        .hreadyout(hreadyout)
    );

    // Decode of the current command.
    acdri_cmd_decode #(
        .NUM_FLAGS(NUM_FLAGS)
    ) u_decode (
        .cmdWord(cmdWord_q),
        .cmdType(cmdType),
        .isListEnd(isListEnd),
        .flagVec(decFlags)
    );

    // Address hits.
    wire hitCtrl = (busAddr == OFF_CTRL);
    wire hitStatus = (busAddr == OFF_STATUS);
    wire hitMask = (busAddr == OFF_MASK);
    wire hitInter = (busAddr == OFF_INTERMEDIATE_INFO);
    wire hitListEnd = (busAddr == OFF_LIST_END_INFO);
    wire hitCmd = (busAddr == OFF_CMD_WORD_0);

    // Control decode; soft reset stays in force until software clears it.
    wire moduleEnable = ctrl_q[CTRL_ENABLE_BIT];
    wire clearInfo = ctrl_q[CTRL_SOFT_RESET_BIT] | ~moduleEnable;
    wire specialAccess = ctrl_q[CTRL_SPECIAL_MODE_ACCESS_BIT];
    wire restartMode = ctrl_q[CTRL_RESTART_MODE_BIT];

    // A finished command counts only while the sequencer runs.
    wire evt = cmdDone & (seqState_q == ST_RUN) & ~clearInfo;
    wire flagEvt = evt & (|decFlags);
    wire listEndEvt = evt & isListEnd;
    wire [7:0] listInfo = {activeCmdList, activeResultList, 6'h00};

    // Register writes; the info registers have no write path at all.
    wire wrCtrl = wrEn & hitCtrl;
    wire wrMask = wrEn & hitMask;
    wire wrCmd = wrEn & hitCmd & specialAccess;
    wire [STAT_W-1:0] statusClr = (wrEn & hitStatus) ? hwdata[STAT_W-1:0] : STAT_RST;
    wire [STAT_W-1:0] statusSet = {convFlagSet(decFlags, flagEvt), listEndEvt};
    // A new event wins over a write-one-to-clear in the same cycle.
    wire [STAT_W-1:0] status_d = (status_q & ~statusClr) | statusSet;
    wire [STAT_W-1:0] mask_d = wrMask ? hwdata[STAT_W-1:0] : mask_q;

    // Gates the decoded flags with the event strobe.
    function automatic logic [NUM_FLAGS:1] convFlagSet(input logic [NUM_FLAGS:1] f,
                                                      input logic en);
        return en ? f : '0;
    endfunction

    // Read selection, one term per register.
    wire [HDATA_W-1:0] rdData =
        ({HDATA_W{hitCtrl}} & {28'h0, ctrl_q}) |
        ({HDATA_W{hitStatus}} & {16'h0, status_q}) |
        ({HDATA_W{hitMask}} & {16'h0, mask_q}) |
        ({HDATA_W{hitInter}} & {24'h0, intermediateResultInfo_q}) |
        ({HDATA_W{hitListEnd}} & {24'h0, endOfListResultInfo_q}) |
        ({HDATA_W{hitCmd}} & {24'h0, cmdWord_q});

    // Sequencer next state; disable or soft reset parks it.
    always_comb begin
        seqState_d = seqState_q;
        unique case (seqState_q)
            ST_STOP: begin
                seqState_d = ST_WAIT_TRIG;
            end
            ST_RUN: begin
                if (evt) begin
                    unique case (cmdType)
                        CT_NORMAL: seqState_d = ST_RUN;
                        CT_END_SEQ: seqState_d = ST_WAIT_TRIG;
                        CT_END_WRAP: seqState_d = ST_RUN;
                        CT_END_WAIT: begin
                            seqState_d = restartMode ? ST_WAIT_RESTART : ST_WAIT_TRIG;
                        end
                    endcase
                end
            end
            ST_WAIT_TRIG: begin
                if (trigger | restart) begin
                    seqState_d = ST_RUN;
                end
            end
            ST_WAIT_RESTART: begin
                if (restart) begin
                    seqState_d = ST_WAIT_TRIG_ONLY;
                end
            end
            ST_WAIT_TRIG_ONLY: begin
                if (trigger) begin
                    seqState_d = ST_RUN;
                end
            end
        endcase
        if (clearInfo) begin
            seqState_d = ST_STOP;
        end
    end

    // Restart accepted while waiting also returns to the list top.
    wire restartTaken = restart & ~clearInfo &
        ((seqState_q == ST_WAIT_TRIG) | (seqState_q == ST_WAIT_RESTART));
    wire wrapNow = (listEndEvt | restartTaken);
    wire advanceNow = evt & ~isListEnd;

    // Software registers.
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            ctrl_q <= CTRL_RST;
            cmdWord_q <= CMD_WORD_RST;
            mask_q <= MASK_RST;
            status_q <= STAT_RST;
        end else begin
            if (wrCtrl) begin
                ctrl_q <= hwdata[CTRL_W-1:0];
            end
            if (wrCmd) begin
                cmdWord_q <= hwdata[7:0] & CMD_WORD_MASK;
            end
            mask_q <= mask_d;
            status_q <= status_d;
        end
    end

    // Info capture in the same edge that raises the matching flag.
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            intermediateResultInfo_q <= INFO_RST;
            endOfListResultInfo_q <= INFO_RST;
        end else if (clearInfo) begin
            intermediateResultInfo_q <= INFO_RST;
            endOfListResultInfo_q <= INFO_RST;
        end else begin
            if (flagEvt) begin
                intermediateResultInfo_q <= listInfo;
            end
            if (listEndEvt) begin
                endOfListResultInfo_q <= listInfo;
            end
        end
    end

    // Event pulses and sequencer outputs, all one cycle after the cmdDone, trigger or restart that causes them.
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            seqState_q <= ST_STOP;
            convFlag_q <= '0;
            listEndFlag_q <= 1'b0;
            cmdAdvance_q <= 1'b0;
            listWrap_q <= 1'b0;
            seqRunning_q <= 1'b0;
            irq_q <= 1'b0;
        end else begin
            seqState_q <= seqState_d;
            convFlag_q <= convFlagSet(decFlags, flagEvt);
            listEndFlag_q <= listEndEvt;
            cmdAdvance_q <= advanceNow;
            listWrap_q <= wrapNow;
            seqRunning_q <= (seqState_d == ST_RUN);
            irq_q <= |(status_d & mask_d);
        end
    end

    // Bus answer; reads are loaded during the single wait state.
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            hrdata_q <= '0;
            hresp_q <= 1'b0;
        end else begin
            hresp_q <= 1'b0;
            if (rdLoad) begin
                hrdata_q <= rdData;
            end
        end
    end

    // Every output leaves straight from its flip-flop, so no input reaches a pin in one cycle.
    assign hrdata = hrdata_q;
    assign hresp = hresp_q;
    assign cmdWord = cmdWord_q;
    assign conversionFlagVector = convFlag_q;
    assign listEndFlag = listEndFlag_q;
    assign cmdAdvance = cmdAdvance_q;
    assign listWrap = listWrap_q;
    assign seqRunning = seqRunning_q;
    assign irq = irq_q;

    // Checks on the decode and capture paths.
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);

    chk_inter_info_sync: assert property (flagEvt |=>
        (convFlag_q == $past(decFlags)) && (intermediateResultInfo_q == $past(listInfo)))
        else $error("Intermediate info not updated with its flag.");
    chk_info_cleared: assert property (clearInfo |=>
        (endOfListResultInfo_q == INFO_RST) && (intermediateResultInfo_q == INFO_RST))
        else $error("Info registers not cleared.");
    chk_info_readonly: assert property ((wrEn && hitListEnd && !listEndEvt && !clearInfo) |=>
        $stable(endOfListResultInfo_q))
        else $error("List-end info changed on a write.");
    chk_cmd_list_bit: assert property (listEndEvt |=>
        endOfListResultInfo_q[INFO_CMD_LIST_BIT] == $past(activeCmdList))
        else $error("Active command list not captured.");
    chk_result_list_bit: assert property (listEndEvt |=>
        endOfListResultInfo_q[INFO_RESULT_LIST_BIT] == $past(activeResultList))
        else $error("Active result list not captured.");
    chk_flag_with_info: assert property (listEndFlag_q |->
        endOfListResultInfo_q == $past(listInfo))
        else $error("List-end flag without matching info update.");
    chk_cmd_locked: assert property ((wrEn && hitCmd && !specialAccess) |=>
        $stable(cmdWord_q))
        else $error("Command word written outside special mode.");
    chk_end_seq_wait: assert property ((evt && cmdType == CT_END_SEQ) |=>
        (seqState_q == ST_WAIT_TRIG) && !seqRunning_q)
        else $error("End of sequence did not wait.");
    chk_wrap_continue: assert property ((evt && cmdType == CT_END_WRAP) |=>
        listWrap_q && seqRunning_q ##1 (seqState_q == ST_RUN || clearInfo || $past(clearInfo)))
        else $error("End of list did not wrap and continue.");
    chk_restart_then_trig: assert property ((evt && cmdType == CT_END_WAIT && restartMode) |=>
        (seqState_q == ST_WAIT_RESTART) && listWrap_q)
        else $error("Restart mode did not wait for restart.");
    chk_flags_onehot: assert property ($onehot0(convFlag_q))
        else $error("Conversion flags not one-hot.");
    chk_flag_source: assert property (listEndFlag_q |-> $past(evt && cmdType[1]))
        else $error("List-end flag from a non list-end command.");
    chk_low_bits_zero: assert property (endOfListResultInfo_q[5:0] == 6'h00)
        else $error("Unused info bits not zero.");

    cov_normal_step: cover property (evt && cmdType == CT_NORMAL ##1 cmdAdvance_q);
    cov_wrap_run: cover property (evt && cmdType == CT_END_WRAP ##1 listWrap_q);
    cov_restart_trig: cover property (seqState_q == ST_WAIT_RESTART ##[1:20] seqState_q == ST_RUN);
    cov_list_end_irq: cover property (listEndFlag_q ##[0:2] irq_q);

endmodule

// ---- dv/acdri_top_tb_top.sv ----
// Purpose: Self-checking bench for the command decode and list-end info block.
// Assumes: The bench is the sole AHB-Lite master and drives the converter side itself.
// Notes: Command word 0 is only edited while the sequencer waits, never mid-sequence.
`timescale 1ns/1ps
`define CHK(got, exp) begin checkCount++; if ((got) !== (exp)) begin miscompares++; \
    $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, (got), (exp)); end end
module acdri_top_tb_top;
    import acdri_pkg::*;
    logic mclk = 1'b0;
    logic nrst = 1'b0;
    logic hsel = 1'b1;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = HSIZE_WORD;
    logic [31:0] hwdata = 32'h0;
    logic cmdDone = 1'b0;
    logic activeCmdList = 1'b0;
    logic activeResultList = 1'b0;
    logic trigger = 1'b0;
    logic restart = 1'b0;
    logic hreadyout, hresp, listEndFlag, cmdAdvance, listWrap, seqRunning, irq;
    logic [31:0] hrdata;
    logic [7:0] cmdWord;
    logic [15:1] conversionFlagVector;
    wire logic hready;
    int miscompares = 0;
    int checkCount = 0;
    logic [31:0] rd;
    logic [15:1] gotFlags;
    logic gotEnd, gotAdv, gotWrap, gotRun;

    // Only one slave sits on the bus, so its ready is the bus ready.
    assign hready = hreadyout;

    acdri_top acdri_top_inst (.mclk(mclk), .nrst(nrst), .hsel(hsel), .htrans(htrans),
        .haddr(haddr), .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .cmdDone(cmdDone),
        .activeCmdList(activeCmdList), .activeResultList(activeResultList),
        .trigger(trigger), .restart(restart), .cmdWord(cmdWord),
        .conversionFlagVector(conversionFlagVector), .listEndFlag(listEndFlag),
        .cmdAdvance(cmdAdvance), .listWrap(listWrap), .seqRunning(seqRunning), .irq(irq));

    // A 4 ns clock period gives the 250 MHz rate.
    always #2 mclk = ~mclk;

    task summarize;
        $display("checks=%0d miscompares=%0d", checkCount, miscompares);
        if (miscompares == 0 && checkCount > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Bounded wait for a ready edge; a stuck slave ends the run instead of hanging it.
    task waitRdy;
        int n;
        n = 0;
        @(posedge mclk);
        while (hreadyout !== 1'b1) begin
            n++;
            if (n > 20) begin
                miscompares++;
                summarize();
            end
            @(posedge mclk);
        end
    endtask

    task busWr(input logic [7:0] a, input logic [31:0] d);
        htrans <= HTRANS_NONSEQ;
        haddr <= {24'h0, a};
        hwrite <= 1'b1;
        waitRdy();
        htrans <= 2'h0;
        hwdata <= d;
        waitRdy();
    endtask

    task rdChk(input logic [7:0] a, input logic [31:0] e);
        htrans <= HTRANS_NONSEQ;
        haddr <= {24'h0, a};
        hwrite <= 1'b0;
        waitRdy();
        htrans <= 2'h0;
        waitRdy();
        rd = hrdata;
        `CHK(rd, e);
    endtask

    // Callers edit the word only while the sequencer waits, never mid-sequence.
    task setCmd(input logic [1:0] t, input logic [3:0] c);
        busWr(OFF_CMD_WORD_0, {24'h0, t, 2'h0, c});
    endtask

    task idle(input int n);
        repeat (n) @(posedge mclk);
    endtask

    // One finished command; the registered answers are caught in the cycle they stand.
    task done(input logic c, input logic r);
        activeCmdList <= c;
        activeResultList <= r;
        cmdDone <= 1'b1;
        @(posedge mclk);
        cmdDone <= 1'b0;
        #1;
        gotFlags = conversionFlagVector;
        gotEnd = listEndFlag;
        gotAdv = cmdAdvance;
        gotWrap = listWrap;
        gotRun = seqRunning;
        @(posedge mclk);
    endtask

    task pulse(input logic isRestart);
        if (isRestart) begin
            restart <= 1'b1;
        end else begin
            trigger <= 1'b1;
        end
        @(posedge mclk);
        trigger <= 1'b0;
        restart <= 1'b0;
        #1;
        gotWrap = listWrap;
        gotRun = seqRunning;
        @(posedge mclk);
    endtask

    task tReset;
        for (int i = 0; i < 6; i++) begin
            rdChk(8'(4 * i), 32'h0);
        end
        `CHK(hresp, 1'b0);
        `CHK(irq, 1'b0);
        $display("test reset values done");
    endtask

    task tAccess;
        busWr(OFF_CMD_WORD_0, 32'h000000FF);
        rdChk(OFF_CMD_WORD_0, 32'h0);
        busWr(OFF_CTRL, 32'h5);
        busWr(OFF_CMD_WORD_0, 32'h000000FF);
        // A byte transfer and a deselected one must both leave the word untouched.
        hsize <= 3'h0;
        busWr(OFF_CMD_WORD_0, 32'h00000041);
        hsize <= HSIZE_WORD;
        hsel <= 1'b0;
        busWr(OFF_CMD_WORD_0, 32'h00000042);
        hsel <= 1'b1;
        rdChk(OFF_CMD_WORD_0, 32'h000000CF);
        `CHK(cmdWord, 8'hCF);
        busWr(OFF_LIST_END_INFO, 32'h000000FF);
        rdChk(OFF_LIST_END_INFO, 32'h0);
        busWr(8'h40, 32'h000000FF);
        rdChk(8'h40, 32'h0);
        $display("test register access done");
    endtask

    // Every flag code, each in an end-of-sequence command so the word changes while idle.
    task tDecode;
        logic [15:1] e;
        logic [3:0] k;
        for (int i = 0; i < 16; i++) begin
            k = i[3:0];
            setCmd(CT_END_SEQ, k);
            pulse(1'b0);
            `CHK(gotRun, 1'b1);
            done(k[0], k[1]);
            e = '0;
            if (i != 0) begin
                e[i] = 1'b1;
            end
            `CHK(gotFlags, e);
            `CHK(gotEnd, 1'b0);
            `CHK({gotAdv, gotWrap}, 2'h2);
            `CHK(seqRunning, 1'b0);
            if (i != 0) begin
                rdChk(OFF_INTERMEDIATE_INFO, {24'h0, k[0], k[1], 6'h0});
            end
        end
        setCmd(CT_NORMAL, 4'h1);
        pulse(1'b0);
        done(1'b0, 1'b0);
        `CHK({gotAdv, gotWrap, gotRun, gotEnd}, 4'hA);
        $display("test decode done");
    endtask

    task tIrq;
        rdChk(OFF_STATUS, 32'h0000FFFE);
        `CHK(irq, 1'b0);
        busWr(OFF_MASK, 32'h8);
        idle(2);
        `CHK(irq, 1'b1);
        busWr(OFF_STATUS, 32'h8);
        idle(2);
        `CHK(irq, 1'b0);
        rdChk(OFF_STATUS, 32'h0000FFF6);
        busWr(OFF_STATUS, 32'h0000FFFF);
        rdChk(OFF_STATUS, 32'h0);
        $display("test interrupt done");
    endtask

    // Both list-end types, both wait modes, and both ways of clearing the info.
    task tListEnd;
        busWr(OFF_CTRL, 32'h4);
        busWr(OFF_CTRL, 32'h5);
        idle(2);
        setCmd(CT_END_WRAP, 4'h3);
        busWr(OFF_MASK, 32'h1);
        pulse(1'b0);
        done(1'b1, 1'b0);
        `CHK(gotFlags, 15'h0004);
        `CHK({gotEnd, gotWrap, gotRun}, 3'h7);
        rdChk(OFF_LIST_END_INFO, 32'h80);
        done(1'b0, 1'b1);
        rdChk(OFF_LIST_END_INFO, 32'h40);
        `CHK(irq, 1'b1);
        busWr(OFF_CTRL, 32'h4);
        rdChk(OFF_LIST_END_INFO, 32'h0);
        busWr(OFF_CTRL, 32'h5);
        idle(2);
        setCmd(CT_END_WAIT, 4'h0);
        pulse(1'b0);
        done(1'b1, 1'b1);
        `CHK({gotEnd, gotWrap, gotRun, gotFlags}, {3'h6, 15'h0});
        rdChk(OFF_LIST_END_INFO, 32'hC0);
        rdChk(OFF_INTERMEDIATE_INFO, 32'h0);
        pulse(1'b1);
        `CHK(gotRun, 1'b1);
        busWr(OFF_CTRL, 32'hD);
        done(1'b1, 1'b0);
        `CHK({gotEnd, gotRun}, 2'h2);
        pulse(1'b0);
        `CHK(gotRun, 1'b0);
        pulse(1'b1);
        `CHK({gotWrap, gotRun}, 2'h2);
        pulse(1'b0);
        `CHK(gotRun, 1'b1);
        busWr(OFF_CTRL, 32'hF);
        rdChk(OFF_LIST_END_INFO, 32'h0);
        $display("test list end done");
    endtask

    // Reset is held three cycles, then the scenarios run in order.
    initial begin
        repeat (3) @(posedge mclk);
        nrst <= 1'b1;
        @(posedge mclk);
        tReset();
        tAccess();
        tDecode();
        tIrq();
        tListEnd();
        summarize();
    end
endmodule
